// file: core/sfpc_defines.svh
`ifndef SFPC_DEFINES_SVH
`define SFPC_DEFINES_SVH
// array geometry
`define SFPC_FLASH_BYTES 32768
`define SFPC_FLASH_AW 15
`define SFPC_FLASH_BASE 16'h8000
`define SFPC_SEC0_LO 16'hF000
`define SFPC_SEC0_HI 16'hFFFF
`define SFPC_SEC1_LO 16'hE000
`define SFPC_SEC1_HI 16'hEFFF
`define SFPC_SEC2_HI 16'hDFFF
`define SFPC_NUM_SECTORS ((`SFPC_FLASH_BYTES <= 4096) ? 2'h1 : ((`SFPC_FLASH_BYTES <= 8192) ? 2'h2 : 2'h3))
`define SFPC_ERASED 8'hFF
// register offsets
`define SFPC_FCSR_ADDR 8'h2B
`define SFPC_ADLO_ADDR 8'h50
`define SFPC_ADHI_ADDR 8'h51
`define SFPC_DATA_ADDR 8'h52
`define SFPC_OPT_ADDR 8'h53
`define SFPC_KEY_ADDR 8'h54
`define SFPC_TEST_ADDR 8'h55
// reset values
`define SFPC_FCSR_RESET 8'h00
`define SFPC_OPT_RESET 8'h00
`define SFPC_DATA_RESET 8'h00
// field positions
`define SFPC_FCSR_BUSY 7
`define SFPC_FCSR_REFUSED 6
`define SFPC_FCSR_ARMED 5
`define SFPC_FCSR_SEC_LSB 4
`define SFPC_OPT_RDP 0
`define SFPC_TEST_EN 0
// unlock keys
`define SFPC_KEY1 8'h56
`define SFPC_KEY2 8'hAE
// cycles after reset release before the mode strap is caught
`define SFPC_CAPTURE_CYCLES 2'h2
`endif

// file: core/sfpc_flash_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfpc_defines.svh"
module sfpc_flash_mem (
  // clock
  input wire logic clk,
  // write port
  input wire sfpc_pkg::sfpc_wr_type wr,
  // read port
  input wire logic rd_en,
  input wire logic [`SFPC_FLASH_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // byte array
  logic [7:0] mem [0:`SFPC_FLASH_BYTES-1];

  // one byte written per cycle, read data registered
  always_ff @(posedge clk)
  begin
    if (wr.en)
    begin
      mem[wr.addr] <= wr.data;
    end
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : sfpc_flash_mem
`default_nettype wire

// file: core/sfpc_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfpc_defines.svh"
module sfpc_guard (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // key register writes
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  // command write consumes the arming
  input wire logic consume,
  // arming state
  output logic armed
);
  typedef enum logic [1:0] {
    SFPC_G_LOCKED = 2'h0,
    SFPC_G_HALF = 2'h1,
    SFPC_G_ARMED = 2'h2
  } sfpc_guard_type;
  // guard state
  sfpc_guard_type g_r;
  sfpc_guard_type g_nxt;

  // two-key unlock, any wrong key relocks
  always_comb
  begin
    g_nxt = g_r;
    unique case (g_r)
      SFPC_G_LOCKED:
        if (key_wr && key_data == `SFPC_KEY1)
          g_nxt = SFPC_G_HALF;
      SFPC_G_HALF:
        if (key_wr)
          g_nxt = (key_data == `SFPC_KEY2) ? SFPC_G_ARMED : SFPC_G_LOCKED;
      SFPC_G_ARMED:
        if (consume || key_wr)
          g_nxt = SFPC_G_LOCKED;
      default:
        g_nxt = SFPC_G_LOCKED;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (reset)
      g_r <= SFPC_G_LOCKED;
    else
      g_r <= g_nxt;
  end

  // armed only for the one next command
  assign armed = (g_r == SFPC_G_ARMED);
endmodule : sfpc_guard
`default_nettype wire

// file: core/sfpc_pkg.sv
package sfpc_pkg;
  // command codes of the control/status register
  typedef enum logic [2:0] {
    SFPC_CMD_NONE = 3'h0,
    SFPC_CMD_PROG = 3'h1,
    SFPC_CMD_SECT = 3'h2,
    SFPC_CMD_MASS = 3'h3,
    SFPC_CMD_OPT = 3'h4
  } sfpc_cmd_type;
  // sequencer states
  typedef enum logic [1:0] {
    SFPC_ST_IDLE = 2'h0,
    SFPC_ST_PROG = 2'h1,
    SFPC_ST_ERASE = 2'h2
  } sfpc_state_type;
  // staged program request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } sfpc_req_type;
  // array write port
  typedef struct packed {
    logic en;
    logic [14:0] addr;
    logic [7:0] data;
  } sfpc_wr_type;
endpackage : sfpc_pkg

// file: core/sfpc_top.sv
// Behaviour
// - erase whole array or sector; program bytes
// - sector erase touches only that sector
// - tool socket: all sectors and options writable
// - in-circuit mode: all sectors and options writable
// - application mode: sector 0 write-protected
// - sector count follows array size
// - sectors 0,1 are 4K at top
// - read-out protection blocks external read, rewrite
// - lifting protection first erases whole array
// - key sequence guards program and erase starts
// - in-circuit test load into RAM supported
// - in-circuit sequence set by RAM routine
// - control/status register 8 bits, 2Bh, 00h
// - application mode runs from sector 0 loader
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sfpc_defines.svh"
module sfpc_top (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // mode pins
  input wire logic tool_socket_mode,
  input wire logic prog_select_high_voltage,
  // cpu fetch address
  input wire logic [15:0] cpu_pc,
  // array read port
  input wire logic fl_rd,
  input wire logic [15:0] fl_addr,
  input wire logic fl_external,
  output logic [7:0] fl_rdata,
  // status outputs
  output logic in_circuit_comm_mode,
  output logic in_circuit_test_load,
  output logic readout_protected,
  output logic busy
);
  // pin synchronisers
  logic [1:0] tool_sync_r;
  logic [1:0] hv_sync_r;
  // mode strap capture
  logic [1:0] cap_cnt_r;
  logic [1:0] cap_cnt_nxt;
  logic icc_r;
  logic icc_nxt;
  // sequencer
  sfpc_pkg::sfpc_state_type state_r;
  sfpc_pkg::sfpc_state_type state_nxt;
  logic [15:0] walk_r;
  logic [15:0] walk_nxt;
  logic [15:0] hi_r;
  logic [15:0] hi_nxt;
  logic [7:0] pdata_r;
  logic [7:0] pdata_nxt;
  logic clr_prot_r;
  logic clr_prot_nxt;
  // software visible state
  sfpc_pkg::sfpc_req_type req_r;
  sfpc_pkg::sfpc_req_type req_nxt;
  sfpc_pkg::sfpc_cmd_type cmd_r;
  sfpc_pkg::sfpc_cmd_type cmd_nxt;
  logic refused_r;
  logic refused_nxt;
  logic [7:0] opt_r;
  logic [7:0] opt_nxt;
  logic test_r;
  logic test_nxt;
  logic [7:0] rdata_nxt;
  // array read masking
  logic block_r;
  logic [7:0] mem_q;
  // write port
  sfpc_pkg::sfpc_wr_type wr;
  // decode helpers
  logic fcsr_wr;
  logic armed;
  logic external;
  logic prot;
  logic boot_ok;
  sfpc_pkg::sfpc_cmd_type wcmd;
  logic [1:0] wsec;
  logic [1:0] psec;

  // sector holding an address, sector 0 at the top
  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= `SFPC_SEC0_LO)
      sector_of = 2'h0;
    else if (a >= `SFPC_SEC1_LO)
      sector_of = 2'h1;
    else
      sector_of = 2'h2;
  endfunction : sector_of
  // is a sector present and writable in the current mode
  function automatic logic sector_ok(input logic [1:0] s, input logic ext);
    sector_ok = (s < `SFPC_NUM_SECTORS)
      && (ext || s != 2'h0);
  endfunction : sector_ok

  // two-flop synchronisers, no reset so the pins are settled by release
  always_ff @(posedge clk)
  begin
    tool_sync_r <= {tool_sync_r[0], tool_socket_mode};
    hv_sync_r <= {hv_sync_r[0], prog_select_high_voltage};
  end

  // key guard against stray register writes
  sfpc_guard u_guard (
    .clk(clk),
    .reset(reset),
    .key_wr(reg_wr && reg_addr == `SFPC_KEY_ADDR),
    .key_data(reg_wdata),
    .consume(fcsr_wr),
    .armed(armed)
  );
  // the array itself
  sfpc_flash_mem u_mem (
    .clk(clk),
    .wr(wr),
    .rd_en(fl_rd),
    .rd_addr(fl_addr[`SFPC_FLASH_AW-1:0]),
    .rd_data(mem_q)
  );
  // mode decode
  assign fcsr_wr = reg_wr && (reg_addr == `SFPC_FCSR_ADDR);
  assign external = tool_sync_r[1] || icc_r;
  assign prot = opt_r[`SFPC_OPT_RDP];
  assign boot_ok = (cpu_pc >= `SFPC_SEC0_LO);
  assign wcmd = sfpc_pkg::sfpc_cmd_type'(reg_wdata[2:0]);
  assign wsec = reg_wdata[`SFPC_FCSR_SEC_LSB+1:`SFPC_FCSR_SEC_LSB];
  assign psec = sector_of(req_r.addr);
  // strap capture and in-circuit mode entry
  always_comb
  begin
    cap_cnt_nxt = cap_cnt_r;
    icc_nxt = icc_r;
    // count up once after release, catch the strap on the last step
    if (cap_cnt_r != `SFPC_CAPTURE_CYCLES)
      cap_cnt_nxt = cap_cnt_r + 2'h1;
    if (cap_cnt_r == `SFPC_CAPTURE_CYCLES - 2'h1)
      icc_nxt = hv_sync_r[1];
  end

  // command acceptance and sequencer
  always_comb
  begin
    state_nxt = state_r;
    walk_nxt = walk_r;
    hi_nxt = hi_r;
    pdata_nxt = pdata_r;
    clr_prot_nxt = clr_prot_r;
    cmd_nxt = cmd_r;
    refused_nxt = refused_r;
    opt_nxt = opt_r;
    wr = '0;
    unique case (state_r)
      sfpc_pkg::SFPC_ST_IDLE:
        if (fcsr_wr && wcmd != sfpc_pkg::SFPC_CMD_NONE)
        begin
          // assume refusal, cleared below when taken
          refused_nxt = 1'b1;
          cmd_nxt = wcmd;
          // locked guard: refuse the command
          if (armed)
          begin
            unique case (wcmd)
              // one byte, any array address the loader picks outside sector 0
              sfpc_pkg::SFPC_CMD_PROG:
                if (req_r.addr >= `SFPC_FLASH_BASE && sector_ok(psec, external)
                    && !(external && prot) && (external || boot_ok))
                begin
                  refused_nxt = 1'b0;
                  walk_nxt = req_r.addr;
                  pdata_nxt = req_r.data;
                  state_nxt = sfpc_pkg::SFPC_ST_PROG;
                end
              // one sector only
              sfpc_pkg::SFPC_CMD_SECT:
                if (sector_ok(wsec, external) && !(external && prot)
                    && (external || boot_ok))
                begin
                  refused_nxt = 1'b0;
                  state_nxt = sfpc_pkg::SFPC_ST_ERASE;
                  // range of the one sector, others untouched
                  walk_nxt = (wsec == 2'h0) ? `SFPC_SEC0_LO : (wsec == 2'h1) ? `SFPC_SEC1_LO : `SFPC_FLASH_BASE;
                  hi_nxt = (wsec == 2'h0) ? `SFPC_SEC0_HI : (wsec == 2'h1) ? `SFPC_SEC1_HI : `SFPC_SEC2_HI;
                end
              // whole array, never from the application
              sfpc_pkg::SFPC_CMD_MASS:
                if (external && !prot)
                begin
                  refused_nxt = 1'b0;
                  walk_nxt = `SFPC_FLASH_BASE;
                  hi_nxt = `SFPC_SEC0_HI;
                  state_nxt = sfpc_pkg::SFPC_ST_ERASE;
                end
              // option byte from the data register
              sfpc_pkg::SFPC_CMD_OPT:
                if (external)
                begin
                  refused_nxt = 1'b0;
                  if (prot && !req_r.data[`SFPC_OPT_RDP])
                  begin
                    // erase everything before unlocking
                    walk_nxt = `SFPC_FLASH_BASE;
                    hi_nxt = `SFPC_SEC0_HI;
                    pdata_nxt = req_r.data;
                    clr_prot_nxt = 1'b1;
                    state_nxt = sfpc_pkg::SFPC_ST_ERASE;
                  end
                  else
                    opt_nxt = req_r.data;
                end
              default:
                refused_nxt = 1'b1;
            endcase
          end
        end
      // single byte write
      sfpc_pkg::SFPC_ST_PROG:
      begin
        wr.en = 1'b1;
        wr.addr = walk_r[`SFPC_FLASH_AW-1:0];
        wr.data = pdata_r;
        state_nxt = sfpc_pkg::SFPC_ST_IDLE;
      end
      // one byte erased per cycle up to the range end
      sfpc_pkg::SFPC_ST_ERASE:
      begin
        wr.en = 1'b1;
        wr.addr = walk_r[`SFPC_FLASH_AW-1:0];
        wr.data = `SFPC_ERASED;
        walk_nxt = walk_r + 16'h0001;
        if (walk_r == hi_r)
        begin
          state_nxt = sfpc_pkg::SFPC_ST_IDLE;
          // protection drops only once the array is blank
          if (clr_prot_r)
          begin
            opt_nxt = pdata_r;
            clr_prot_nxt = 1'b0;
          end
        end
      end
      default:
        state_nxt = sfpc_pkg::SFPC_ST_IDLE;
    endcase
  end

  // staging, test control and register read data
  always_comb
  begin
    req_nxt = req_r;
    test_nxt = test_r;
    rdata_nxt = 8'h00;
    // staging registers take writes at any time
    if (reg_wr)
    begin
      unique case (reg_addr)
        `SFPC_ADLO_ADDR: req_nxt.addr[7:0] = reg_wdata;
        `SFPC_ADHI_ADDR: req_nxt.addr[15:8] = reg_wdata;
        `SFPC_DATA_ADDR: req_nxt.data = reg_wdata;
        `SFPC_TEST_ADDR: test_nxt = reg_wdata[`SFPC_TEST_EN];
        default: req_nxt = req_r;
      endcase
    end
    // reads answer next cycle, unmapped reads zero
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SFPC_FCSR_ADDR: rdata_nxt = {busy, refused_r, armed, 2'h0, cmd_r};
        `SFPC_ADLO_ADDR: rdata_nxt = req_r.addr[7:0];
        `SFPC_ADHI_ADDR: rdata_nxt = req_r.addr[15:8];
        `SFPC_DATA_ADDR: rdata_nxt = req_r.data;
        `SFPC_OPT_ADDR: rdata_nxt = opt_r;
        `SFPC_TEST_ADDR: rdata_nxt = {7'h00, test_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cap_cnt_r <= 2'h0;
      icc_r <= 1'b0;
      state_r <= sfpc_pkg::SFPC_ST_IDLE;
      walk_r <= 16'h0000;
      hi_r <= 16'h0000;
      pdata_r <= `SFPC_DATA_RESET;
      clr_prot_r <= 1'b0;
      req_r <= '0;
      cmd_r <= sfpc_pkg::SFPC_CMD_NONE;
      refused_r <= 1'b0;
      opt_r <= `SFPC_OPT_RESET;
      test_r <= 1'b0;
      reg_rdata <= `SFPC_FCSR_RESET;
      block_r <= 1'b0;
    end
    else
    begin
      cap_cnt_r <= cap_cnt_nxt;
      icc_r <= icc_nxt;
      state_r <= state_nxt;
      walk_r <= walk_nxt;
      hi_r <= hi_nxt;
      pdata_r <= pdata_nxt;
      clr_prot_r <= clr_prot_nxt;
      req_r <= req_nxt;
      cmd_r <= cmd_nxt;
      refused_r <= refused_nxt;
      opt_r <= opt_nxt;
      test_r <= test_nxt;
      reg_rdata <= rdata_nxt;
      // external reads of a protected array read as zero
      if (fl_rd)
        block_r <= fl_external && prot;
    end
  end

  // outputs
  assign fl_rdata = mem_q & {8{~block_r}};
  assign busy = (state_r != sfpc_pkg::SFPC_ST_IDLE);
  assign in_circuit_comm_mode = icc_r;
  assign in_circuit_test_load = icc_r && test_r;
  assign readout_protected = prot;
endmodule : sfpc_top
`default_nettype wire

// file: sim/sector_flash_program_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module sector_flash_program_control_test;
  // clock, reset and counters
  logic clk = 1'b0;
  logic reset = 1'b1;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] v;
  // register port and cpu address
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] cpu_pc = 16'hF000;
  // device outputs and tool lines
  logic [7:0] reg_rdata, fl_rdata;
  logic tool_socket_mode, prog_select_high_voltage, fl_rd, fl_external;
  logic [15:0] fl_addr;
  logic in_circuit_comm_mode, in_circuit_test_load, readout_protected, busy;
  // 125 MHz clock
  always #4 clk = ~clk;
  sfpc_top i_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tool_socket_mode,
    .prog_select_high_voltage, .cpu_pc, .fl_rd, .fl_addr, .fl_external, .fl_rdata, .in_circuit_comm_mode,
    .in_circuit_test_load, .readout_protected, .busy);
  sfpc_tool_model i_tool (.clk, .tool_socket_mode, .prog_select_high_voltage, .fl_rd, .fl_addr, .fl_external,
    .fl_rdata);
  // compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle register write
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // register read, data checked in the following cycle
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd
  // unlock, command, wait for idle
  task run(input logic [7:0] cmd);
    wr(8'h54, 8'h56);
    wr(8'h54, 8'hAE);
    wr(8'h2B, cmd);
    @(posedge clk);
    #1;
    while (busy === 1'b1)
    begin
      @(posedge clk);
      #1;
    end
  endtask : run
  // address, data, then byte program
  task prog(input logic [15:0] a, input logic [7:0] d);
    wr(8'h50, a[7:0]);
    wr(8'h51, a[15:8]);
    wr(8'h52, d);
    run(8'h01);
  endtask : prog
  // array byte read and compare
  task fl(input logic ext, input logic [15:0] a, input logic [7:0] exp);
    i_tool.read(ext, a, v);
    chk(v, exp);
  endtask : fl
  // reset held four cycles, then strap settles
  task do_reset;
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : do_reset
  // counts, verdict, end of run
  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // main sequence
  initial
  begin
    i_tool.set_mode(1'b1, 1'b0);
    do_reset();
    rd(8'h2B, 8'h00);
    rd(8'h60, 8'h00);
    run(8'h12);
    rd(8'h2B, 8'h02);
    prog(16'hE000, 8'h3C);
    run(8'h02);
    prog(16'hF000, 8'hA5);
    fl(1'b1, 16'hE000, 8'h3C);
    fl(1'b1, 16'hF000, 8'hA5);
    fl(1'b1, 16'hF001, 8'hFF);
    fl(1'b1, 16'hEFFF, 8'hFF);
    // wrong second key, then command
    wr(8'h54, 8'h56);
    wr(8'h54, 8'h12);
    wr(8'h52, 8'h99);
    wr(8'h2B, 8'h01);
    rd(8'h2B, 8'h41);
    fl(1'b1, 16'hF000, 8'hA5);
    // unknown command code is refused
    run(8'h07);
    rd(8'h2B, 8'h47);
    // application mode, running from the loader, then from outside it
    i_tool.set_mode(1'b0, 1'b0);
    repeat (4) @(posedge clk);
    prog(16'hF000, 8'h00);
    rd(8'h2B, 8'h41);
    fl(1'b0, 16'hF000, 8'hA5);
    run(8'h02);
    rd(8'h2B, 8'h42);
    prog(16'hE001, 8'h5A);
    rd(8'h2B, 8'h01);
    run(8'h22);
    rd(8'h2B, 8'h02);
    fl(1'b0, 16'hDFFF, 8'hFF);
    fl(1'b0, 16'hE001, 8'h5A);
    run(8'h03);
    rd(8'h2B, 8'h43);
    @(posedge clk);
    cpu_pc <= 16'h1000;
    prog(16'hE002, 8'h11);
    rd(8'h2B, 8'h41);
    // protection set and lifted from the tool
    i_tool.set_mode(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    wr(8'h52, 8'h01);
    run(8'h04);
    wr(8'h53, 8'hFF);
    rd(8'h53, 8'h01);
    chk({7'h00, readout_protected}, 8'h01);
    fl(1'b1, 16'hF000, 8'h00);
    fl(1'b0, 16'hF000, 8'hA5);
    prog(16'hE000, 8'h00);
    rd(8'h2B, 8'h41);
    run(8'h04);
    rd(8'h53, 8'h00);
    fl(1'b1, 16'hF000, 8'hFF);
    fl(1'b1, 16'hE001, 8'hFF);
    // in-circuit mode from the select strap
    i_tool.set_mode(1'b0, 1'b1);
    do_reset();
    chk({7'h00, in_circuit_comm_mode}, 8'h01);
    wr(8'h55, 8'h01);
    @(posedge clk);
    #1;
    chk({7'h00, in_circuit_test_load}, 8'h01);
    prog(16'hF002, 8'h77);
    fl(1'b1, 16'hF002, 8'h77);
    report_and_stop();
  end
endmodule : sector_flash_program_control_test
`default_nettype wire

// file: sim/sfpc_tool_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfpc_tool_model (
  // clock
  input wire logic clk,
  // mode lines
  output logic tool_socket_mode,
  output logic prog_select_high_voltage,
  // array read link
  output logic fl_rd,
  output logic [15:0] fl_addr,
  output logic fl_external,
  input wire logic [7:0] fl_rdata
);
  // programmer idle at power-up
  initial
  begin
    tool_socket_mode = 1'b0;
    prog_select_high_voltage = 1'b0;
    fl_rd = 1'b0;
    fl_addr = 16'h0000;
    fl_external = 1'b0;
  end
  // plug in or select in-circuit mode ahead of reset release
  task set_mode(input logic tool, input logic sel);
    @(posedge clk);
    tool_socket_mode <= tool;
    prog_select_high_voltage <= sel;
  endtask : set_mode
  // one byte read, address line released to its inverse after
  task read(input logic ext, input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    fl_rd <= 1'b1;
    fl_addr <= a;
    fl_external <= ext;
    @(posedge clk);
    fl_rd <= 1'b0;
    fl_addr <= ~a;
    #1;
    d = fl_rdata;
  endtask : read
endmodule : sfpc_tool_model
`default_nettype wire

// file: sim/sfpc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sfpc_top_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // array read port
  input wire logic fl_rd,
  input wire logic fl_external,
  input wire logic [7:0] fl_rdata,
  // status outputs
  input wire logic in_circuit_comm_mode,
  input wire logic in_circuit_test_load,
  input wire logic readout_protected,
  input wire logic busy
);
  // length of the current busy run
  logic [15:0] len_r;
  logic [15:0] len_nxt;
  // count while busy, clear when idle
  always_comb
  begin
    len_nxt = busy ? len_r + 16'h0001 : 16'h0000;
  end
  // register the run length
  always_ff @(posedge clk)
  begin
    if (reset)
      len_r <= 16'h0000;
    else
      len_r <= len_nxt;
  end
  // one domain: shared clock and disable
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !busy && !readout_protected && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without a read");
  chk_busy_cause: assert property ($rose(busy) |-> $past(reg_wr) && $past(reg_addr) == 8'h2B)
    else $error("busy rose without a command write");
  chk_prog_short: assert property (reg_wr && reg_addr == 8'h2B && reg_wdata[2:0] == 3'h1 && !busy ##1 busy |=> !busy)
    else $error("byte program longer than one cycle");
  chk_busy_length: assert property ($fell(busy) |-> len_r inside {16'h0001, 16'h1000, 16'h6000, 16'h8000})
    else $error("busy ran a wrong length");
  chk_prot_read: assert property (fl_rd && fl_external && readout_protected |=> fl_rdata == 8'h00)
    else $error("protected array read leaked");
  chk_lift_erase: assert property ($fell(readout_protected) |-> $past(len_r) >= 16'h7000)
    else $error("protection lifted without full erase");
  chk_test_mode: assert property (in_circuit_test_load |-> in_circuit_comm_mode)
    else $error("test load outside in-circuit mode");
  // main scenarios reached
  cover property ($fell(busy) && len_r == 16'h1000);
  cover property ($fell(busy) && len_r == 16'h6000);
  cover property ($fell(readout_protected));
  cover property (fl_rd && fl_external && readout_protected);
endmodule : sfpc_top_chk
bind sfpc_top sfpc_top_chk i_chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fl_rd,
  .fl_external, .fl_rdata, .in_circuit_comm_mode, .in_circuit_test_load, .readout_protected, .busy);
`default_nettype wire
